//--- dv/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic sys_clk,
  output logic [1:0] pins
);
  initial pins = 2'b11;
  // level held a whole number of cycles; pin is never left floating
  task automatic hold(input int i, input logic v, input int n);
    pins[i] <= v;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- dv/pwt_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwt_asserts
  import pwt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire apb_req_t apbReq,
  input wire apb_rsp_t apbRsp,
  input wire logic powerDown,
  input wire logic ctr0Irq,
  input wire logic ctr1Irq,
  input wire logic wakeUp,
  input wire logic [NUM_CTR-1:0] pullHighEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic acc = apbReq.psel && apbReq.penable;
  wire logic wrPort = acc && apbReq.pwrite && apbReq.paddr == ADDR_PORT_CONTROL;
  wire logic wrIrq = acc && apbReq.pwrite && apbReq.paddr == ADDR_IRQ_CONTROL;
  a_ready_const: assert property (apbRsp.pready) else $error("pready low");
  a_err_phase: assert property (apbRsp.pslverr |-> acc) else $error("pslverr outside access");
  a_err_zero: assert property (acc && !apbReq.pwrite && apbRsp.pslverr |-> apbRsp.prdata == '0)
    else $error("unmapped read not zero");
  a_pull_load: assert property (wrPort |=> pullHighEn == $past(apbReq.pwdata[5:4])) else $error("pull not loaded");
  a_pull_hold: assert property (!wrPort |=> $stable(pullHighEn)) else $error("pull changed");
  a_pull_read: assert property (acc && !apbReq.pwrite && apbReq.paddr == ADDR_PORT_CONTROL
    |-> apbRsp.prdata[5:4] == pullHighEn) else $error("pull readback");
  a_irq_mask: assert property (wrIrq && !apbReq.pwdata[0] |=> !ctr0Irq && !ctr1Irq) else $error("irq unmasked");
  a_irq_set: assert property (wrIrq && apbReq.pwdata[5:0] == 6'h37 |=> ctr0Irq && ctr1Irq)
    else $error("irq not raised");
  a_wake_pd: assert property (wakeUp |-> $past(powerDown)) else $error("wake while awake");
  a_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("wake too long");
  c_wake: cover property (wakeUp);
  c_irq: cover property (ctr0Irq);
  c_err: cover property (apbRsp.pslverr);
endmodule
bind pulse_width_timer_counter pwt_asserts chk (.sys_clk(sys_clk), .rstn(rstn), .apbReq(apbReq),
  .apbRsp(apbRsp), .powerDown(powerDown), .ctr0Irq(ctr0Irq), .ctr1Irq(ctr1Irq), .wakeUp(wakeUp),
  .pullHighEn(pullHighEn));
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pwt_pkg::*;
  logic sys_clk = 0;
  logic rstn = 0;
  logic powerDown = 0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [1:0] pins;
  logic irq0;
  logic irq1;
  logic wake;
  logic [1:0] pull;
  logic [31:0] rd;
  logic [31:0] rng = 32'h0032;
  logic err;
  int fail_count = 0;
  int n_tests = 0;
  int wakes = 0;
  localparam logic [7:0] RESET_REGS [4] = '{ADDR_CTR0_CONTROL, ADDR_CTR1_CONTROL, ADDR_IRQ_CONTROL, ADDR_PORT_CONTROL};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake === 1'b1) wakes <= wakes + 1;
  pin_source src (.sys_clk(sys_clk), .pins(pins));
  pulse_width_timer_counter uut (.sys_clk(sys_clk), .rstn(rstn), .apbReq(req), .apbRsp(rsp),
    .ctr0InputPin(pins[0]), .ctr1InputPin(pins[1]), .powerDown(powerDown), .ctr0Irq(irq0),
    .ctr1Irq(irq1), .wakeUp(wake), .pullHighEn(pull));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chkr(input string s, input int lo, input int hi, input logic [31:0] g);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fail_count++;
      $display("mismatch %s exp %0d..%0d got %h", s, lo, hi, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge sys_clk);
  endtask
  // high byte first latches the low byte
  task automatic rdcnt(input int c, output logic [31:0] v);
    logic [7:0] hi;
    if (c == 0) begin
      apb(0, ADDR_CTR0_COUNT, 0);
      v = rd;
    end else begin
      apb(0, ADDR_CTR1_HIGH_BYTE, 0);
      hi = rd[7:0];
      apb(0, ADDR_CTR1_LOW_BYTE, 0);
      v = {16'h0000, hi, rd[7:0]};
    end
  endtask
  initial begin
    logic [7:0] ctl;
    logic [7:0] cb;
    logic [31:0] cnt;
    logic [31:0] v;
    int w;
    int wbase;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (RESET_REGS[i]) begin
      apb(0, RESET_REGS[i], 0);
      chk("reset", 0, rd);
    end
    apb(0, 8'h40, 0);
    chk("slverr", 1, err);
    apb(1, ADDR_PORT_CONTROL, 32'h0000_0033);
    chk("pull", 3, pull);
    for (int c = 0; c < 2; c++) begin
      ctl = c ? ADDR_CTR1_CONTROL : ADDR_CTR0_CONTROL;
      cb = c ? 8'hC8 : 8'hC0;
      if (c == 0) apb(1, ADDR_CTR0_COUNT, 0);
      else begin
        apb(1, ADDR_CTR1_LOW_BYTE, 0);
        apb(1, ADDR_CTR1_HIGH_BYTE, 0);
      end
      src.hold(c, c[0], 4);
      apb(1, ctl, cb);
      apb(1, ctl, cb | 8'h10);
      src.hold(c, !c[0], 20);
      rdcnt(c, v);
      chk("armed", 0, v);
      rng = xs(rng);
      w = 16 + rng[5:0];
      src.hold(c, c[0], w);
      src.hold(c, !c[0], 12);
      apb(0, ctl, 0);
      chk("runclr", cb, rd);
      rdcnt(c, cnt);
      chkr("width", w / 4 - 1, w / 4 + 1, cnt);
      src.hold(c, c[0], 20);
      src.hold(c, !c[0], 12);
      rdcnt(c, v);
      chk("hold", cnt, v);
    end
    apb(1, ADDR_CTR0_COUNT, 32'h0000_00F0);
    apb(1, ADDR_IRQ_CONTROL, 0);
    apb(1, ADDR_CTR0_CONTROL, 32'h0000_0080);
    apb(1, ADDR_CTR0_CONTROL, 32'h0000_0090);
    repeat (100) @(posedge sys_clk);
    apb(0, ADDR_IRQ_CONTROL, 0);
    chk("flag", 32'h0000_0010, rd);
    chk("irqoff", 0, irq0);
    apb(0, ADDR_CTR0_CONTROL, 0);
    chk("runkeep", 32'h0000_0090, rd);
    rdcnt(0, v);
    chkr("reload", 'hF0, 'hFF, v);
    apb(1, ADDR_IRQ_CONTROL, 32'h0000_0013);
    chk("irqon", 1, irq0);
    chk("irq1off", 0, irq1);
    apb(1, ADDR_IRQ_CONTROL, 32'h0000_0037);
    chk("irq1on", 1, irq1);
    src.hold(0, 1'b0, 4);
    apb(1, ADDR_CTR0_CONTROL, 32'h0000_0040);
    apb(1, ADDR_CTR0_COUNT, 32'h0000_00FE);
    apb(1, ADDR_IRQ_CONTROL, 0);
    apb(1, ADDR_CTR0_CONTROL, 32'h0000_0050);
    for (int k = 0; k < 2; k++) begin
      powerDown <= 1'b1;
      wbase = wakes;
      repeat (2) begin
        src.hold(0, 1'b1, 4);
        src.hold(0, 1'b0, 4);
      end
      repeat (8) @(posedge sys_clk);
      chk("wake", 1 - k, wakes - wbase);
      apb(1, ADDR_IRQ_CONTROL, 32'h0000_0010);
    end
    powerDown <= 1'b0;
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

//--- hw/count_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module count_clock_divider
  import pwt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enable,
  output logic tick
);

  typedef struct packed {
    logic [1:0] phase;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  always_comb begin
    next_st = st;
    if (enable) begin
      next_st.phase = (st.phase == DIV_LAST) ? 2'h0 : st.phase + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = enable && (st.phase == DIV_LAST);

endmodule
`default_nettype wire

//--- hw/pin_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
  import pwt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pin,
  input wire logic sampleEn,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic sample;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = pin;
    next_st.sync = st.meta;
    if (sampleEn) begin
      next_st.sample = st.sync;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // edges only seen at the sample points, so width error is one sample period
  assign rise = sampleEn && st.sync && !st.sample;
  assign fall = sampleEn && !st.sync && st.sample;

endmodule
`default_nettype wire

//--- hw/pulse_width_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_width_timer_counter
  import pwt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire apb_req_t apbReq,
  output apb_rsp_t apbRsp,
  input wire logic ctr0InputPin,
  input wire logic ctr1InputPin,
  input wire logic powerDown,
  output logic ctr0Irq,
  output logic ctr1Irq,
  output logic wakeUp,
  output logic [NUM_CTR-1:0] pullHighEn
);

  typedef struct packed {
    chan_t [NUM_CTR-1:0] ch;
    logic globalIrqEnable;
    logic [NUM_CTR-1:0] irqEnable;
    logic [NUM_CTR-1:0] pinIsInput;
    logic [NUM_CTR-1:0] pullHigh;
    logic [7:0] lowWriteBuf;
    logic [7:0] lowReadLatch;
    logic [DATA_W-1:0] rdata;
    logic wake;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic tick;
  logic [NUM_CTR-1:0] pinRaw;
  logic [NUM_CTR-1:0] sampleEn;
  logic [NUM_CTR-1:0] pinRise;
  logic [NUM_CTR-1:0] pinFall;

  logic setup;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic mapped;

  assign pinRaw = {ctr1InputPin, ctr0InputPin};

  // the divided clock stops in power-down while the system clock keeps running
  count_clock_divider u_divider (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .enable(!powerDown),
    .tick(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CTR; gi++) begin : g_pin
      // event mode samples every cycle: no prescaling of pin edges
      assign sampleEn[gi] = (st.ch[gi].control[MODE_HI:MODE_LO] == MODE_EVENT) ? 1'b1 : tick;
      pin_edge_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin(pinRaw[gi]),
        .sampleEn(sampleEn[gi]),
        .rise(pinRise[gi]),
        .fall(pinFall[gi])
      );
    end
  endgenerate

  assign setup = apbReq.psel && !apbReq.penable;
  assign access = apbReq.psel && apbReq.penable;
  assign wrAccess = access && apbReq.pwrite;
  assign rdAccess = access && !apbReq.pwrite;

  always_comb begin
    case (apbReq.paddr)
      ADDR_CTR0_CONTROL,
      ADDR_CTR0_COUNT,
      ADDR_CTR1_CONTROL,
      ADDR_CTR1_LOW_BYTE,
      ADDR_CTR1_HIGH_BYTE,
      ADDR_IRQ_CONTROL,
      ADDR_PORT_CONTROL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    logic [15:0] full;
    logic [1:0] mode;
    logic run;
    logic pol;
    logic pinSel;
    logic inhibit;
    logic countEn;
    logic startEdge;
    logic stopEdge;
    logic [NUM_CTR-1:0] ovf;
    logic [7:0] wbyte;
    full = FULL_CTR0;
    mode = MODE_NONE;
    run = 1'b0;
    pol = 1'b0;
    pinSel = 1'b0;
    inhibit = 1'b0;
    countEn = 1'b0;
    startEdge = 1'b0;
    stopEdge = 1'b0;
    ovf = '0;
    wbyte = apbReq.pwdata[7:0];
    next_st = st;
    next_st.wake = 1'b0;

    for (int i = 0; i < NUM_CTR; i++) begin
      full = (i == 0) ? FULL_CTR0 : FULL_CTR1;
      mode = st.ch[i].control[MODE_HI:MODE_LO];
      run = st.ch[i].control[RUN_BIT];
      pol = st.ch[i].control[POL_BIT];
      pinSel = ((mode == MODE_EVENT) || (mode == MODE_PULSE)) && st.pinIsInput[i];
      if (i == 0) begin
        inhibit = access && ((rdAccess && apbReq.paddr == ADDR_CTR0_COUNT)
          || (wrAccess && apbReq.paddr == ADDR_CTR0_COUNT));
      end else begin
        inhibit = access && ((apbReq.paddr == ADDR_CTR1_LOW_BYTE) || (apbReq.paddr == ADDR_CTR1_HIGH_BYTE));
      end
      startEdge = pinSel && (pol ? pinRise[i] : pinFall[i]);
      stopEdge = pinSel && (pol ? pinFall[i] : pinRise[i]);

      case (mode)
        MODE_TIMER: begin
          countEn = run && tick && !inhibit;
        end
        MODE_EVENT: begin
          // pin edges still arrive during power-down
          countEn = run && pinSel && (pol ? pinFall[i] : pinRise[i]) && !inhibit;
        end
        MODE_PULSE: begin
          countEn = run && st.ch[i].measuring && tick && !inhibit;
          if (run && !st.ch[i].measuring && startEdge) begin
            next_st.ch[i].measuring = 1'b1;
          end
          if (run && st.ch[i].measuring && stopEdge) begin
            next_st.ch[i].measuring = 1'b0;
            next_st.ch[i].control[RUN_BIT] = 1'b0;
            countEn = 1'b0;
          end
        end
        default: begin
          countEn = 1'b0;
        end
      endcase

      // with run clear no edge is seen and the residual count holds
      if (!run) begin
        next_st.ch[i].measuring = 1'b0;
      end

      if (countEn) begin
        if ((st.ch[i].count & full) == full) begin
          next_st.ch[i].count = st.ch[i].preload & full;
          ovf[i] = 1'b1;
        end else begin
          next_st.ch[i].count = (st.ch[i].count + 16'h0001) & full;
        end
      end
    end

    // control writes; mode must be settled by an earlier write
    if (wrAccess && apbReq.paddr == ADDR_CTR0_CONTROL) begin
      next_st.ch[0].control = wbyte;
      if (!wbyte[RUN_BIT]) begin
        next_st.ch[0].measuring = 1'b0;
      end
    end
    if (wrAccess && apbReq.paddr == ADDR_CTR1_CONTROL) begin
      next_st.ch[1].control = wbyte;
      if (!wbyte[RUN_BIT]) begin
        next_st.ch[1].measuring = 1'b0;
      end
    end

    // preload writes
    if (wrAccess && apbReq.paddr == ADDR_CTR0_COUNT) begin
      next_st.ch[0].preload = {8'h00, wbyte};
      if (!st.ch[0].control[RUN_BIT]) begin
        next_st.ch[0].count = {8'h00, wbyte};
      end
    end
    if (wrAccess && apbReq.paddr == ADDR_CTR1_LOW_BYTE) begin
      next_st.lowWriteBuf = wbyte;
    end
    if (wrAccess && apbReq.paddr == ADDR_CTR1_HIGH_BYTE) begin
      next_st.ch[1].preload = {wbyte, st.lowWriteBuf};
      if (!st.ch[1].control[RUN_BIT]) begin
        next_st.ch[1].count = {wbyte, st.lowWriteBuf};
      end
    end
    if (rdAccess && apbReq.paddr == ADDR_CTR1_HIGH_BYTE) begin
      next_st.lowReadLatch = st.ch[1].count[7:0];
    end

    // interrupt control; a hardware set beats a software clear
    if (wrAccess && apbReq.paddr == ADDR_IRQ_CONTROL) begin
      next_st.globalIrqEnable = apbReq.pwdata[GLOBAL_EN_BIT];
      next_st.irqEnable = apbReq.pwdata[IRQ_EN_LSB +: NUM_CTR];
      for (int i = 0; i < NUM_CTR; i++) begin
        next_st.ch[i].flag = apbReq.pwdata[FLAG_LSB + i];
      end
    end
    for (int i = 0; i < NUM_CTR; i++) begin
      if (ovf[i]) begin
        next_st.ch[i].flag = 1'b1;
        // a flag left set before power-down blocks the wake
        if (powerDown && !st.ch[i].flag) begin
          next_st.wake = 1'b1;
        end
      end
    end

    if (wrAccess && apbReq.paddr == ADDR_PORT_CONTROL) begin
      next_st.pinIsInput = apbReq.pwdata[DIR_LSB +: NUM_CTR];
      next_st.pullHigh = apbReq.pwdata[PULL_LSB +: NUM_CTR];
    end

    // read data captured in the setup cycle
    if (setup) begin
      next_st.rdata = '0;
      case (apbReq.paddr)
        ADDR_CTR0_CONTROL: next_st.rdata[7:0] = st.ch[0].control;
        ADDR_CTR0_COUNT: next_st.rdata[7:0] = st.ch[0].count[7:0];
        ADDR_CTR1_CONTROL: next_st.rdata[7:0] = st.ch[1].control;
        ADDR_CTR1_LOW_BYTE: next_st.rdata[7:0] = st.lowReadLatch;
        ADDR_CTR1_HIGH_BYTE: next_st.rdata[7:0] = st.ch[1].count[15:8];
        ADDR_IRQ_CONTROL: begin
          next_st.rdata[GLOBAL_EN_BIT] = st.globalIrqEnable;
          next_st.rdata[IRQ_EN_LSB +: NUM_CTR] = st.irqEnable;
          next_st.rdata[FLAG_LSB] = st.ch[0].flag;
          next_st.rdata[FLAG_LSB + 1] = st.ch[1].flag;
        end
        ADDR_PORT_CONTROL: begin
          next_st.rdata[DIR_LSB +: NUM_CTR] = st.pinIsInput;
          next_st.rdata[PULL_LSB +: NUM_CTR] = st.pullHigh;
        end
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign apbRsp.prdata = st.rdata;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = access && !mapped;

  assign ctr0Irq = st.globalIrqEnable && st.irqEnable[0] && st.ch[0].flag;
  assign ctr1Irq = st.globalIrqEnable && st.irqEnable[1] && st.ch[1].flag;
  assign wakeUp = st.wake;
  // pull-high does not depend on timer use of the pin
  assign pullHighEn = st.pullHigh;

endmodule
`default_nettype wire

//--- pkg/pwt_pkg.sv
package pwt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CTR = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTR0_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTR0_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTR1_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTR1_LOW_BYTE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CTR1_HIGH_BYTE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CONTROL = 8'h18;

  // control byte fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RUN_BIT = 4;
  localparam int POL_BIT = 3;

  // interrupt control fields
  localparam int GLOBAL_EN_BIT = 0;
  localparam int IRQ_EN_LSB = 1;
  localparam int FLAG_LSB = 4;

  // port control fields
  localparam int DIR_LSB = 0;
  localparam int PULL_LSB = 4;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } ctr_mode_t;

  localparam logic [15:0] FULL_CTR0 = 16'h00FF;
  localparam logic [15:0] FULL_CTR1 = 16'hFFFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // counting clock is the system clock divided by this
  localparam int CLK_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [15:0] preload;
    logic measuring;
    logic flag;
  } chan_t;

endpackage
